/* File: core/rcpr_defines.vh */
// Constants of the reset cause and peripheral reset block.
// Assumes inclusion by bare name from the top-level design file and the sim files.
// Overview of operation
// - Peripherals stay in reset while the run bit is 0; bit resets to 0.
// - Active-low peripheral reset output follows the run bit directly.
// - Peripheral reset register bits 31 to 1 read undefined, writes ignored.
// - Clocking field reads back the synchronised clock-selection pins.
// - Writing the clocking field requests a switch to the written scheme.
// - Codes 000, 010, 101, 110, 111 are valid; 001, 011, 100 reserved.
// - Clocking field reads all zeros after reset.
// - Status bits 10 to 7 are read-only and undefined.
// - Status bit 6 shows DSP global idle; resets to 0. Here it follows dspIdle directly, even in and right after reset.
// - Bit 5 set by power-on reset, reads 1 after reset, cleared by 0.
// - Bit 4 set while external reset asserted, reads 1, cleared by 0.
// - Writing 1 never sets any reset cause flag.
// - Bit 3 set by MPU core reset; cleared by pin reset or write 0.
// - Bit 2 set by MPU watchdog reset; cleared by pin or write 0.
// - Bit 1 set by global soft reset; cleared by pin or write 0.
// - One master write with DSP run 0 and MPU reset 1 starts global reset.
// - Bit 0 set by DSP watchdog reset, resets 0, cleared by write 0.
// - MPU core reset bit reads 0 and self-clears after one cycle.
`ifndef RCPR_DEFINES_VH
`define RCPR_DEFINES_VH

// Register byte offsets on the peripheral bus
`define RCPR_OFS_MASTER 8'h10
`define RCPR_OFS_PERIPH 8'h14
`define RCPR_OFS_STATUS 8'h18

// Master reset register fields
`define RCPR_MST_MPU_RST 0
`define RCPR_MST_DSP_RUN 1
`define RCPR_MST_SYS_RST 3
`define RCPR_DSP_RUN_RESET 1'h0

// Peripheral reset register field
`define RCPR_PER_RUN 0
`define RCPR_PER_RUN_RESET 1'h0

// Status register fields
`define RCPR_ST_DSP_WD 0
`define RCPR_ST_GLOB_SW 1
`define RCPR_ST_MPU_WD 2
`define RCPR_ST_MPU_CORE 3
`define RCPR_ST_PIN 4
`define RCPR_ST_POR 5
`define RCPR_ST_DSP_IDLE 6
`define RCPR_ST_CLK_LSB 11
`define RCPR_ST_CLK_MSB 13
`define RCPR_FLAG_COUNT 6
`define RCPR_FLAG_RESET 6'h38
`define RCPR_CLK_RESET 3'h0

// Clocking scheme codes
`define RCPR_CLK_FULL_SYNC 3'h0
`define RCPR_CLK_SYNC_SCALE 3'h2
`define RCPR_CLK_BYPASS 3'h5
`define RCPR_CLK_MIX_THREE 3'h6
`define RCPR_CLK_MIX_FOUR 3'h7

`endif

/* File: core/rcpr_sync3.v */
// Three-stage pin synchroniser with agreement filter.
// Assumes asynchronous pin levels; output moves only when stages two and three agree.
module rcpr_sync3
#(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
)
(
   input wire mclk,                 // Block clock
   input wire rst,                  // Synchronous reset, active high
   input wire [WIDTH-1:0] pinIn,    // Raw pin levels
   output wire [WIDTH-1:0] stable   // Filtered, synchronised levels
);

   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1)
      begin : bitSync
         reg stageOne;
         reg stageTwo;
         reg stageThree;
         reg held;
         // Stage one feeds only stage two, so metastability never reaches logic
         always @(posedge mclk)
         begin
            if (rst)
            begin
               stageOne <= RESET_VAL[i];
               stageTwo <= RESET_VAL[i];
               stageThree <= RESET_VAL[i];
               held <= RESET_VAL[i];
            end
            else
            begin
               stageOne <= pinIn[i];
               stageTwo <= stageOne;
               stageThree <= stageTwo;
               if (stageTwo == stageThree)
                  held <= stageThree;
            end
         end
         assign stable[i] = held;
      end
   endgenerate

endmodule

/* File: core/rcpr_flag.v */
// One sticky reset-cause flag.
// Assumes set and clear requests come from logic on mclk.
module rcpr_flag
#(
   parameter [0:0] RESET_VAL = 1'b0
)
(
   input wire mclk,       // Block clock
   input wire rst,        // Synchronous reset, active high
   input wire setEvent,   // Hardware cause seen this cycle
   input wire clearReq,   // Software or pin clear this cycle
   output reg flag        // Sticky flag value
);

   wire next_flag;

   assign next_flag = setEvent | (flag & ~clearReq);

   // Reset value chosen per flag by the parent
   always @(posedge mclk)
   begin
      if (rst)
         flag <= RESET_VAL;
      else
         flag <= next_flag;
   end

endmodule

/* File: core/rcpr_top.v */
// Reset cause status, peripheral reset and clocking-mode request logic.
// Assumes a simple peripheral bus on mclk: one-cycle read or write strobes,
// address stable with the strobe; pins arrive asynchronously.
// Assumes dspIdle and both watchdog inputs come from logic on mclk, so they
// pass no synchroniser and each high cycle counts as one event.
`include "rcpr_defines.vh"

module rcpr_top
(
   input wire mclk,                   // 200 MHz block clock
   input wire rst,                    // Power-on reset, synchronous, active high
   input wire [7:0] busAddr,          // Peripheral bus byte address
   input wire busWrite,               // Write strobe, one cycle
   input wire busRead,                // Read strobe, one cycle
   input wire [31:0] busWdata,        // Write data
   output reg [31:0] busRdata,        // Read data, valid with busReady
   output reg busReady,               // Access done, one-cycle pulse
   input wire devResetPinN,           // Chip reset pin, active low
   input wire [2:0] clockSelectPins,  // Clock selection pins
   input wire mpuWatchdogUnderflow,   // MPU watchdog reset pulse
   input wire dspWatchdogUnderflow,   // DSP watchdog reset pulse
   input wire dspIdle,                // DSP core in global idle
   output wire mpuPeripheralResetN,   // Peripheral reset, active low
   output reg dspRun,                 // DSP core released from reset
   output reg mpuCoreReset,           // MPU core reset, one-cycle pulse
   output reg globalSoftReset,        // Global software reset pulse
   output reg systemReset,            // Whole-system reset pulse
   output reg clockSwitchReq,         // Clocking switch request pulse
   output reg [2:0] clockSwitchMode   // Requested clocking scheme
);

   // Software-visible control state
   reg peripheralRun;

   // Synchronised pin levels
   wire pinStableN;
   wire [2:0] clockSelectStable;

   // Decoded bus strobes
   wire masterWrite;
   wire periphWrite;
   wire statusWrite;

   // Reset cause events and clears, one bit per flag
   wire [`RCPR_FLAG_COUNT-1:0] flagSet;
   wire [`RCPR_FLAG_COUNT-1:0] flagClear;
   wire [`RCPR_FLAG_COUNT-1:0] flagValue;
   wire [`RCPR_FLAG_COUNT-1:0] softClear;
   wire pinClear;

   // Named flag views for readability
   wire dspWatchdogResetFlag;
   wire globalSoftResetFlag;
   wire mpuWatchdogResetFlag;
   wire mpuCoreResetFlag;
   wire pinResetFlag;
   wire powerOnFlag;

   // Master register decode
   wire mpuResetReq;
   wire globalStart;
   wire sysResetReq;

   // Clocking request decode
   wire [2:0] writtenMode;
   wire modeValid;

   // Next values
   reg [31:0] next_busRdata;
   reg next_mpuCoreReset;
   reg next_globalSoftReset;
   reg next_systemReset;
   reg next_clockSwitchReq;

   genvar f;

   // Per-flag reset values; a bit select hands each flag exactly one bit
   localparam [`RCPR_FLAG_COUNT-1:0] flagResetBits = `RCPR_FLAG_RESET;

   // Validity of a clocking code; reserved codes are refused
   function isValidMode;
      input [2:0] mode;
      begin
         case (mode)
            `RCPR_CLK_FULL_SYNC: isValidMode = 1'b1;
            `RCPR_CLK_SYNC_SCALE: isValidMode = 1'b1;
            `RCPR_CLK_BYPASS: isValidMode = 1'b1;
            `RCPR_CLK_MIX_THREE: isValidMode = 1'b1;
            `RCPR_CLK_MIX_FOUR: isValidMode = 1'b1;
            default: isValidMode = 1'b0;
         endcase
      end
   endfunction

   // Chip reset pin; idles high so reset value is 1
   // Seeding the filter with the idle level stops a false pin event after reset
   rcpr_sync3
   #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   )
   pinSync
   (
      .mclk(mclk),
      .rst(rst),
      .pinIn(devResetPinN),
      .stable(pinStableN)
   );

   // Mode pins are filtered like the reset pin; a read shortly after reset
   // shows zero until the filter has settled on the pins.
   // zero after reset
   rcpr_sync3
   #(
      .WIDTH(3),
      .RESET_VAL(`RCPR_CLK_RESET)
   )
   clockSelSync
   (
      .mclk(mclk),
      .rst(rst),
      .pinIn(clockSelectPins),
      .stable(clockSelectStable)
   );

   // Address decode of write strobes
   // Only the low address byte is decoded; the bus fabric selects the block
   assign masterWrite = busWrite & (busAddr == `RCPR_OFS_MASTER);
   assign periphWrite = busWrite & (busAddr == `RCPR_OFS_PERIPH);
   assign statusWrite = busWrite & (busAddr == `RCPR_OFS_STATUS);

   // Master register: MPU reset and global reset requests
   // A global reset write also carries the core reset bit, so it pulses the
   // core reset and sets the core cause flag along with the global one.
   assign mpuResetReq = masterWrite & busWdata[`RCPR_MST_MPU_RST];
   assign globalStart = mpuResetReq & ~busWdata[`RCPR_MST_DSP_RUN];
   assign sysResetReq = masterWrite & busWdata[`RCPR_MST_SYS_RST];

   // Peripheral run bit; only bit 0 is stored
   // Peripherals leave reset only when software says so, never on their own
   always @(posedge mclk)
   begin
      if (rst)
         peripheralRun <= `RCPR_PER_RUN_RESET;
      else if (periphWrite)
         peripheralRun <= busWdata[`RCPR_PER_RUN];
   end

   assign mpuPeripheralResetN = peripheralRun;

   // DSP run bit; a global reset write carries 0 here and so halts the DSP
   // The DSP stays held after power-on or any master write with this bit 0, until software writes 1 here
   always @(posedge mclk)
   begin
      if (rst)
         dspRun <= `RCPR_DSP_RUN_RESET;
      else if (masterWrite)
         dspRun <= busWdata[`RCPR_MST_DSP_RUN];
   end

   // Self-clearing reset pulses from the master register
   // Pulses are registered so the reset targets see a clean one-cycle level
   always @*
   begin
      next_mpuCoreReset = mpuResetReq;
      next_globalSoftReset = globalStart;
      next_systemReset = sysResetReq;
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         mpuCoreReset <= 1'b0;
         globalSoftReset <= 1'b0;
         systemReset <= 1'b0;
      end
      else
      begin
         mpuCoreReset <= next_mpuCoreReset;
         globalSoftReset <= next_globalSoftReset;
         systemReset <= next_systemReset;
      end
   end

   // Clocking switch request; refusing reserved codes keeps the clock tree sane
   // Limitation: every status write carries a mode, so software that only
   // clears flags must write a reserved code, or it requests a switch.
   // A repeated valid code still pulses; the receiver treats it as a no-op.
   assign writtenMode = busWdata[`RCPR_ST_CLK_MSB:`RCPR_ST_CLK_LSB];
   assign modeValid = isValidMode(writtenMode);

   always @*
   begin
      next_clockSwitchReq = statusWrite & modeValid;
   end

   always @(posedge mclk)
   begin
      if (rst)
      begin
         clockSwitchReq <= 1'b0;
         clockSwitchMode <= `RCPR_CLK_RESET;
      end
      else
      begin
         clockSwitchReq <= next_clockSwitchReq;
         if (next_clockSwitchReq)
            clockSwitchMode <= writtenMode;
      end
   end

   // Pin reset is a level: flags follow it for as long as it is held
   // Taking the level rather than an edge clears the MPU-side causes on every cycle of
   // the pulse, but set wins, so a cause raised on the last low cycle survives it.
   assign pinClear = ~pinStableN;

   assign softClear = statusWrite ? ~busWdata[`RCPR_FLAG_COUNT-1:0] : {`RCPR_FLAG_COUNT{1'b0}};

   // Hardware causes per flag
   // Watchdog inputs are pulses from mclk logic, so no edge detect is needed
   // DSP watchdog sets
   assign flagSet[`RCPR_ST_DSP_WD] = dspWatchdogUnderflow;
   assign flagSet[`RCPR_ST_GLOB_SW] = globalStart;
   assign flagSet[`RCPR_ST_MPU_WD] = mpuWatchdogUnderflow;
   assign flagSet[`RCPR_ST_MPU_CORE] = mpuResetReq;
   assign flagSet[`RCPR_ST_PIN] = pinClear;
   // only reset sets; reset value carries it
   assign flagSet[`RCPR_ST_POR] = 1'b0;

   // Clear sources per flag; pin reset clears the MPU-side causes
   assign flagClear[`RCPR_ST_DSP_WD] = softClear[`RCPR_ST_DSP_WD];
   assign flagClear[`RCPR_ST_GLOB_SW] = softClear[`RCPR_ST_GLOB_SW] | pinClear;
   assign flagClear[`RCPR_ST_MPU_WD] = softClear[`RCPR_ST_MPU_WD] | pinClear;
   assign flagClear[`RCPR_ST_MPU_CORE] = softClear[`RCPR_ST_MPU_CORE] | pinClear;
   assign flagClear[`RCPR_ST_PIN] = softClear[`RCPR_ST_PIN];
   assign flagClear[`RCPR_ST_POR] = softClear[`RCPR_ST_POR];

   // One sticky flag per cause
   // Each flag is its own small module, so the set-wins rule lives in one place
   // and a change to it cannot drift between flags.
   generate
      for (f = 0; f < `RCPR_FLAG_COUNT; f = f + 1)
      begin : causeFlag
         rcpr_flag
         #(
            .RESET_VAL(flagResetBits[f])
         )
         flagBit
         (
            .mclk(mclk),
            .rst(rst),
            .setEvent(flagSet[f]),
            .clearReq(flagClear[f]),
            .flag(flagValue[f])
         );
      end
   endgenerate

   assign dspWatchdogResetFlag = flagValue[`RCPR_ST_DSP_WD];
   assign globalSoftResetFlag = flagValue[`RCPR_ST_GLOB_SW];
   assign mpuWatchdogResetFlag = flagValue[`RCPR_ST_MPU_WD];
   assign mpuCoreResetFlag = flagValue[`RCPR_ST_MPU_CORE];
   assign pinResetFlag = flagValue[`RCPR_ST_PIN];
   assign powerOnFlag = flagValue[`RCPR_ST_POR];

   // Read multiplexer; undefined bits return zero so reads are repeatable
   // Zeros cost nothing here and let software compare whole words; code must
   // still mask the undefined bits, as another build may return other values.
   always @*
   begin
      next_busRdata = 32'h0;
      if (busRead)
      begin
         case (busAddr)
            `RCPR_OFS_MASTER:
            begin
               next_busRdata[`RCPR_MST_MPU_RST] = 1'b0;
               next_busRdata[`RCPR_MST_DSP_RUN] = dspRun;
            end
            `RCPR_OFS_PERIPH:
            begin
               next_busRdata[`RCPR_PER_RUN] = peripheralRun;
            end
            `RCPR_OFS_STATUS:
            begin
               next_busRdata[`RCPR_ST_CLK_MSB:`RCPR_ST_CLK_LSB] = clockSelectStable;
               next_busRdata[`RCPR_ST_DSP_IDLE] = dspIdle;
               next_busRdata[`RCPR_ST_POR] = powerOnFlag;
               next_busRdata[`RCPR_ST_PIN] = pinResetFlag;
               next_busRdata[`RCPR_ST_MPU_CORE] = mpuCoreResetFlag;
               next_busRdata[`RCPR_ST_MPU_WD] = mpuWatchdogResetFlag;
               next_busRdata[`RCPR_ST_GLOB_SW] = globalSoftResetFlag;
               next_busRdata[`RCPR_ST_DSP_WD] = dspWatchdogResetFlag;
            end
            default:
            begin
               // Unmapped addresses read zero
               next_busRdata = 32'h0;
            end
         endcase
      end
   end

   // Bus answer one cycle after any strobe; data held until the next read
   // Writes are answered too, so a master sees the same latency on every
   // access; back-to-back strobes give back-to-back answers.
   always @(posedge mclk)
   begin
      if (rst)
      begin
         busRdata <= 32'h0;
         busReady <= 1'b0;
      end
      else
      begin
         busReady <= busRead | busWrite;
         if (busRead)
            busRdata <= next_busRdata;
      end
   end

endmodule

/* File: sim/rcpr_props.sv */
// Concurrent checks on the ports of the reset cause block.
// Assumes binding into rcpr_top; one clock, synchronous reset.
`include "rcpr_defines.vh"
module rcpr_props
(
   input wire mclk,                  // Block clock
   input wire rst,                   // Synchronous reset
   input wire [7:0] busAddr,         // Byte address
   input wire busWrite,              // Write strobe
   input wire busRead,               // Read strobe
   input wire [31:0] busWdata,       // Write data
   input wire [31:0] busRdata,       // Read data
   input wire busReady,              // Access done
   input wire dspIdle,               // DSP idle level
   input wire mpuPeripheralResetN,   // Peripheral reset
   input wire mpuCoreReset,          // Core reset pulse
   input wire globalSoftReset,       // Global reset pulse
   input wire clockSwitchReq,        // Switch pulse
   input wire [2:0] clockSwitchMode  // Requested mode
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // Reserved clock codes must never start a switch
   wire [2:0] wrCode = busWdata[13:11];
   wire codeOk = (wrCode != 3'h1) && (wrCode != 3'h3) && (wrCode != 3'h4);
   sequence s_wrMaster;
      busWrite && busAddr == `RCPR_OFS_MASTER;
   endsequence
   sequence s_wrStatus;
      busWrite && busAddr == `RCPR_OFS_STATUS;
   endsequence
   sequence s_rd(a);
      busRead && busAddr == a;
   endsequence
   sequence s_onePulse(x);
      x ##1 !x;
   endsequence
   property p_ready;
      busReady == $past(busWrite || busRead);
   endproperty
   property p_perRun;
      busWrite && busAddr == `RCPR_OFS_PERIPH |=> mpuPeripheralResetN == $past(busWdata[0]);
   endproperty
   property p_coreRst;
      s_wrMaster ##0 busWdata[0] |=> s_onePulse(mpuCoreReset);
   endproperty
   property p_globRst;
      s_wrMaster ##0 busWdata[1:0] == 2'b01 |=> s_onePulse(globalSoftReset);
   endproperty
   property p_globNone;
      s_wrMaster ##0 busWdata[1] |=> !globalSoftReset;
   endproperty
   property p_clkSw;
      s_wrStatus ##0 codeOk |=> clockSwitchReq && clockSwitchMode == $past(wrCode);
   endproperty
   property p_clkRsv;
      s_wrStatus ##0 !codeOk |=> !clockSwitchReq;
   endproperty
   property p_mstRead;
      s_rd(`RCPR_OFS_MASTER) |=> busRdata[0] == 1'b0;
   endproperty
   property p_perRead;
      s_rd(`RCPR_OFS_PERIPH) |=> busRdata[31:1] == 31'h0 && busRdata[0] == mpuPeripheralResetN;
   endproperty
   property p_stRsv;
      s_rd(`RCPR_OFS_STATUS) |=> busRdata[10:7] == 4'h0;
   endproperty
   property p_idle;
      s_rd(`RCPR_OFS_STATUS) |=> busRdata[6] == $past(dspIdle);
   endproperty
   a_ready: assert property (p_ready) else $error("busReady not one cycle after strobe");
   a_perRun: assert property (p_perRun) else $error("peripheral reset not following run bit");
   a_coreRst: assert property (p_coreRst) else $error("core reset not a single pulse");
   a_globRst: assert property (p_globRst) else $error("global reset not pulsed");
   a_globNone: assert property (p_globNone) else $error("global reset with DSP run set");
   a_clkSw: assert property (p_clkSw) else $error("clock switch not requested");
   a_clkRsv: assert property (p_clkRsv) else $error("reserved clock code accepted");
   a_mstRead: assert property (p_mstRead) else $error("core reset bit read as 1");
   a_perRead: assert property (p_perRead) else $error("peripheral register read wrong");
   a_stRsv: assert property (p_stRsv) else $error("status reserved bits nonzero");
   a_idle: assert property (p_idle) else $error("idle bit not DSP state");
endmodule

/* File: sim/rcpr_tb.sv */
// Self-checking bench for the reset cause and peripheral reset block.
// Assumes rcpr_top and rcpr_props compiled first; one 200 MHz clock.
`include "rcpr_defines.vh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] busAddr = 8'h00;
   logic busWrite = 1'b0;
   logic busRead = 1'b0;
   logic [31:0] busWdata = 32'h0;
   logic devResetPinN = 1'b1;
   logic [2:0] clockSelectPins = 3'h0;
   logic mpuWatchdogUnderflow = 1'b0;
   logic dspWatchdogUnderflow = 1'b0;
   logic dspIdle = 1'b0;
   wire [31:0] busRdata;
   wire [2:0] clockSwitchMode;
   wire busReady, mpuPeripheralResetN, dspRun, mpuCoreReset, globalSoftReset, systemReset, clockSwitchReq;
   int n_mismatch = 0;
   int samples_checked = 0;
   rcpr_top dut (.mclk(mclk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite), .busRead(busRead),
      .busWdata(busWdata), .busRdata(busRdata), .busReady(busReady), .devResetPinN(devResetPinN),
      .clockSelectPins(clockSelectPins), .mpuWatchdogUnderflow(mpuWatchdogUnderflow),
      .dspWatchdogUnderflow(dspWatchdogUnderflow), .dspIdle(dspIdle), .mpuPeripheralResetN(mpuPeripheralResetN),
      .dspRun(dspRun), .mpuCoreReset(mpuCoreReset), .globalSoftReset(globalSoftReset),
      .systemReset(systemReset), .clockSwitchReq(clockSwitchReq), .clockSwitchMode(clockSwitchMode));
   // Free-running 5 ns clock
   initial
   begin
      forever #2.5 mclk = ~mclk;
   end
   // Strobe one cycle, then look just after the taking edge
   task automatic busWr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      busAddr <= a;
      busWdata <= d;
      busWrite <= 1'b1;
      @(posedge mclk);
      busWrite <= 1'b0;
      #1;
      `CHK(busReady, 1'b1)
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e);
      @(posedge mclk);
      busAddr <= a;
      busRead <= 1'b1;
      @(posedge mclk);
      busRead <= 1'b0;
      #1;
      `CHK(busReady, 1'b1)
      `CHK(busRdata, e)
   endtask
   task automatic t_periph;
      `CHK(mpuPeripheralResetN, 1'b0)
      rdChk(`RCPR_OFS_PERIPH, 32'h0);
      busWr(`RCPR_OFS_PERIPH, 32'hffffffff);
      `CHK(mpuPeripheralResetN, 1'b1)
      rdChk(`RCPR_OFS_PERIPH, 32'h1);
      busWr(`RCPR_OFS_PERIPH, 32'hfffffffe);
      `CHK(mpuPeripheralResetN, 1'b0)
      busWr(`RCPR_OFS_MASTER, 32'h2);
      `CHK(dspRun, 1'b1)
      rdChk(`RCPR_OFS_MASTER, 32'h2);
      busWr(`RCPR_OFS_MASTER, 32'h8);
      `CHK(systemReset, 1'b1) // Whole-system pulse
      `CHK(dspRun, 1'b0)
      @(posedge mclk);
      #1;
      `CHK(systemReset, 1'b0) // One cycle only
      busWr(`RCPR_OFS_MASTER, 32'h0);
      rdChk(8'h20, 32'h0);
      $display("test periph done");
   endtask
   task automatic t_flags;
      rdChk(`RCPR_OFS_STATUS, 32'h38);
      busWr(`RCPR_OFS_STATUS, 32'h3f);
      rdChk(`RCPR_OFS_STATUS, 32'h38);
      busWr(`RCPR_OFS_STATUS, 32'h0);
      rdChk(`RCPR_OFS_STATUS, 32'h0);
      @(posedge mclk);
      mpuWatchdogUnderflow <= 1'b1;
      dspWatchdogUnderflow <= 1'b1;
      @(posedge mclk);
      mpuWatchdogUnderflow <= 1'b0;
      dspWatchdogUnderflow <= 1'b0;
      rdChk(`RCPR_OFS_STATUS, 32'h5);
      // Clear lands on the same edge as a DSP watchdog event
      fork
         busWr(`RCPR_OFS_STATUS, 32'h0);
         begin
            @(posedge mclk);
            dspWatchdogUnderflow <= 1'b1;
            @(posedge mclk);
            dspWatchdogUnderflow <= 1'b0;
         end
      join
      rdChk(`RCPR_OFS_STATUS, 32'h1);
      @(posedge mclk);
      mpuWatchdogUnderflow <= 1'b1;
      @(posedge mclk);
      mpuWatchdogUnderflow <= 1'b0;
      busWr(`RCPR_OFS_MASTER, 32'h1);
      `CHK(mpuCoreReset, 1'b1)
      `CHK(globalSoftReset, 1'b1)
      rdChk(`RCPR_OFS_MASTER, 32'h0);
      `CHK(mpuCoreReset, 1'b0)
      rdChk(`RCPR_OFS_STATUS, 32'hf);
      @(posedge mclk);
      devResetPinN <= 1'b0;
      repeat (10) @(posedge mclk);
      devResetPinN <= 1'b1;
      repeat (10) @(posedge mclk);
      rdChk(`RCPR_OFS_STATUS, 32'h11);
      busWr(`RCPR_OFS_STATUS, 32'h0);
      $display("test flags done");
   endtask
   task automatic t_clock;
      logic ok;
      for (int c = 0; c < 8; c++)
      begin
         busWr(`RCPR_OFS_STATUS, {18'h0, c[2:0], 11'h7ff});
         ok = !(c == 1 || c == 3 || c == 4);
         `CHK(clockSwitchReq, ok)
         if (ok)
            `CHK(clockSwitchMode, c[2:0])
      end
      @(posedge mclk);
      clockSelectPins <= 3'h6;
      dspIdle <= 1'b1;
      repeat (10) @(posedge mclk);
      rdChk(`RCPR_OFS_STATUS, 32'h3040);
      $display("test clock done");
   endtask
   // Mid-run reset: run bit drops and the power-on flag is set again
   task automatic t_reset;
      busWr(`RCPR_OFS_PERIPH, 32'h1);
      `CHK(mpuPeripheralResetN, 1'b1)
      @(posedge mclk);
      rst <= 1'b1;
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      #1;
      `CHK(mpuPeripheralResetN, 1'b0)
      `CHK(clockSwitchMode, 3'h0)
      rdChk(`RCPR_OFS_STATUS, 32'h78);
      $display("test reset done");
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // Main sequence after five reset cycles
   initial
   begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_periph();
      t_flags();
      t_clock();
      t_reset();
      tally_and_finish();
   end
   // Hang guard, far beyond the hundred or so cycles the tests need
   initial
   begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
bind rcpr_top rcpr_props u_props (.mclk(mclk), .rst(rst), .busAddr(busAddr), .busWrite(busWrite),
   .busRead(busRead), .busWdata(busWdata), .busRdata(busRdata), .busReady(busReady), .dspIdle(dspIdle),
   .mpuPeripheralResetN(mpuPeripheralResetN), .mpuCoreReset(mpuCoreReset), .globalSoftReset(globalSoftReset),
   .clockSwitchReq(clockSwitchReq), .clockSwitchMode(clockSwitchMode));
